// ---- rtl/burst_mode_pkg.sv ----
// Package of mode-register layout, encodings and timing counts for the burst/mode block
package burst_mode_pkg;

  // ***************************************************************
  // Mode-set address layout
  // ***************************************************************
  localparam int MODE_BITS = 22;              // Register bits carried by a mode-set command
  localparam int SEL_LSB = 18;                // Register select field, bits 20:18
  localparam logic [2:0] SEL_ZERO = 3'h0;     // Selects mode_register_zero
  localparam logic [2:0] SEL_ONE = 3'h1;      // Selects mode_register_one
  localparam int RSVD_HI_BIT = 21;            // Reserved, must be written 0
  localparam int RSVD_LO_BIT = 17;            // Reserved, must be written 0

  // ***************************************************************
  // mode_register_zero fields
  // ***************************************************************
  localparam int BL_LSB = 0;                  // Burst length field, bits 1:0
  localparam int BT_BIT = 3;                  // burst_ordering_type bit
  localparam int TM_BIT = 7;                  // vendor_test_mode bit
  localparam int LOOP_RST_BIT = 8;            // Loop reset request, self-clearing
  localparam int WR_LSB = 9;                  // Write recovery low bits 11:9
  localparam int WR_HI_BIT = 13;              // Write recovery high bit
  localparam logic [1:0] BL_EIGHT = 2'h0;     // Fixed eight_beat_burst
  localparam logic [1:0] BL_OTF = 2'h1;       // per_command_length_select
  localparam logic [1:0] BL_CHOP = 2'h2;      // Fixed four_beat_chop
  localparam logic [1:0] BL_RSVD = 2'h3;      // Reserved encoding

  // ***************************************************************
  // mode_register_one fields
  // ***************************************************************
  localparam int AL_LSB = 3;                  // additive_latency code, bits 4:3
  localparam int TERM_STROBE_BIT = 11;        // termination_strobe enable
  localparam int OUTPUT_OFF_BIT = 12;         // Output buffer disable

  // ***************************************************************
  // Reset values and timing
  // ***************************************************************
  localparam logic [21:0] MR_ZERO_RESET = 22'h000000; // Eight-beat, sequential, shortest latency
  localparam logic [21:0] MR_ONE_RESET = 22'h000000;  // Outputs on, no additive latency
  localparam int CHOP_PULL_IN = 2;            // Chop write starts this many clocks early
  localparam int WRITE_START_BASE = 4;        // Clocks from write command to internal write
  localparam int CRC_CHECK_DELAY = 2;         // Clocks from internal write start to CRC verdict

  typedef enum logic [1:0] {BURST_EIGHT, BURST_OTF, BURST_CHOP, BURST_RSVD} burst_len_t;

endpackage : burst_mode_pkg

// ---- rtl/beat_link_if.sv ----
// Interface carrying ordered beats between the block and its beat buffer
`timescale 1ns/100ps
interface beat_link_if #(parameter int W = 8);
  logic valid;      // Beat present
  logic ready;      // Receiver accepts beat
  logic [W-1:0] data; // Beat payload
  logic last;       // Final beat of burst
  modport src (output valid, output data, output last, input ready);
  modport dst (input valid, input data, input last, output ready);
endinterface : beat_link_if

// ---- rtl/beat_buffer.sv ----
// Two-entry skid buffer for read beats, valid/ready on both sides
`timescale 1ns/100ps
module beat_buffer #(
  parameter int W = 8,
  parameter int DEPTH = 2
)(
  input wire logic clk,          // Device clock
  input wire logic rst_b,        // Async reset, active low
  beat_link_if.dst in_side,      // Filling side
  output logic out_valid,        // Beat ready for receiver
  input wire logic out_ready,    // Receiver takes beat
  output logic [W-1:0] out_data, // Beat payload
  output logic out_last          // Final beat of burst
);

  // ***************************************************************
  // Storage
  // ***************************************************************
  logic [W:0] mem [DEPTH];       // Payload plus last flag
  logic [$clog2(DEPTH)-1:0] wr_ptr; // Write slot
  logic [$clog2(DEPTH)-1:0] rd_ptr; // Read slot
  logic [$clog2(DEPTH):0] count;    // Entries held
  logic push;                       // Beat accepted
  logic pop;                        // Beat delivered

  assign push = in_side.valid && in_side.ready;
  assign pop = out_valid && out_ready;
  // Back-pressure: full refuses the source
  assign in_side.ready = (count != ($clog2(DEPTH)+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr][W-1:0];
  assign out_last = mem[rd_ptr][W];

  // Write side pointer and storage
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wr_ptr <= '0;
      for (int i = 0; i < DEPTH; i++)
        mem[i] <= '0;
    end
    else if (push)
    begin
      mem[wr_ptr] <= {in_side.last, in_side.data};
      wr_ptr <= wr_ptr + 1'b1;
    end
  end

  // Read side pointer
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      rd_ptr <= '0;
    else if (pop)
      rd_ptr <= rd_ptr + 1'b1;
  end

  // Occupancy count
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      count <= '0;
    else if (push && !pop)
      count <= count + 1'b1;
    else if (pop && !push)
      count <= count - 1'b1;
  end

endmodule : beat_buffer

// ---- rtl/latency_pipe.sv ----
// Delay line that times the first read beat from read_latency
`timescale 1ns/100ps
module latency_pipe #(
  parameter int DEPTH = 64
)(
  input wire logic clk,          // Device clock
  input wire logic rst_b,        // Async reset, active low
  input wire logic start,        // Read registered
  input wire logic [5:0] delay,  // Clocks to first beat, at least 1
  output logic fire              // Pulse when delay has elapsed
);

  // ***************************************************************
  // Shift line
  // ***************************************************************
  logic [DEPTH-1:0] line;        // One bit per clock of delay

  // Shift in the start, tap at the programmed depth
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      line <= '0;
    else
      line <= {line[DEPTH-2:0], start};
  end

  // Tap is whole clocks only; no half-clock latency exists
  assign fire = line[delay - 6'h01];

endmodule : latency_pipe

// ---- rtl/burst_mode_core.sv ----
// Mode-register decode, burst ordering, read latency and write commit for the memory device
// Operation
// R1: Order beats from length, type, start column
// R2: Sample burst_chop_n with each column command
// R3: Sequential eight: wrap nibble, then other nibble
// R4: Interleaved eight: beat equals start XOR count
// R5: Chopped read: four beats in nibble
// R6: Chopped read: last four slots high impedance
// R7: Chopped write: column bit 2 only, fixed
// R8: Eight-beat write: always order 0 to 7
// R9: Fixed chop starts internal write two early
// R10: Per-command mode keeps eight-beat write timing
// R11: First data whole clocks after internal read
// R12: Read latency is additive plus column latency
// R13: Controller keeps vendor test bit zero
// R14: Controller programs write recovery large enough
// R15: CRC mismatch with masking cancels the write
// R16: Controller programs read-to-precharge large enough
// R17: Loop reset bit clears itself after issue
// R18: Controller waits lock time after loop reset
// R19: Mode-set maps bank and address to bits
// R20: Controller writes reserved bits 21, 17 zero
// R21: output_off disables drivers and termination
// R22: Bit 11 enables termination strobe pins
// R23: Burst length codes: eight, select, chop, reserved
// R24: Bit 3 picks sequential or interleaved order
// R25: Registers hold until next mode-set write
`timescale 1ns/100ps
module burst_mode_core #(
  parameter int BEAT_W = 8,       // Data bits per beat
  parameter bit WIDE_X8 = 1'b1    // Eight-bit-wide configuration
)(
  input wire logic clk,                 // Device clock
  input wire logic rst_b,               // Async reset, active low
  input wire logic mode_set,            // Mode-set command strobe
  input wire logic [21:0] mode_addr,    // Bank group, bank, address pins
  input wire logic rd_cmd,              // READ registered
  input wire logic wr_cmd,              // WRITE registered
  input wire logic [2:0] start_col,     // Starting column bits 2:0
  input wire logic burst_chop_n,        // Low selects chop in select mode
  input wire logic mask_en,             // data_masking enabled
  input wire logic crc_en,              // Write CRC enabled
  input wire logic crc_ok,              // CRC verdict for pending write
  input wire logic [BEAT_W-1:0] arr_beat [8], // Array beats of read burst
  input wire logic rd_ready,            // Receiver takes read beat
  output logic rd_valid,                // Read beat valid
  output logic [BEAT_W-1:0] rd_data,    // Read beat data
  output logic rd_last,                 // Final read beat
  output logic [2:0] rd_index,          // Column index of current slot
  output logic dq_oe_b,                 // Data driver enable, low drives
  output logic dqs_oe_b,                // Strobe driver enable, low drives
  output logic term_off,                // Termination disabled
  output logic term_strobe_en,          // termination_strobe pins active
  output logic loop_reset,              // Loop reset pulse to delay loop
  output logic wr_start,                // Internal write begins
  output logic wr_commit,               // Write data committed to array
  output logic wr_cancel,               // Write discarded on CRC error
  output logic [7:0] wr_beat_map,       // Beat slots written, bit per index
  output logic [21:0] mode_zero_view,   // Stored mode_register_zero
  output logic [21:0] mode_one_view     // Stored mode_register_one
);

  // ***************************************************************
  // Mode registers
  // ***************************************************************
  logic [21:0] mode_register_zero;      // Burst, latency, recovery fields
  logic [21:0] mode_register_one;       // Output, termination, additive fields
  logic [2:0] mode_sel;                 // Target of current mode-set
  burst_mode_pkg::burst_len_t burst_len; // Decoded burst length
  logic interleave;                     // burst_ordering_type
  logic output_off;                     // Output buffers disabled

  assign mode_sel = mode_addr[burst_mode_pkg::SEL_LSB +: 3];
  // R23: length codes decoded
  assign burst_len = burst_mode_pkg::burst_len_t'(mode_register_zero[burst_mode_pkg::BL_LSB +: 2]);
  // R24: ordering type bit
  assign interleave = mode_register_zero[burst_mode_pkg::BT_BIT];
  assign output_off = mode_register_one[burst_mode_pkg::OUTPUT_OFF_BIT];

  // Mode register zero store; loop reset bit never stays set
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      mode_register_zero <= burst_mode_pkg::MR_ZERO_RESET;
    // R19: pins map straight to bits
    else if (mode_set && mode_sel == burst_mode_pkg::SEL_ZERO)
      mode_register_zero <= mode_addr;
    // R17: bit self-clears after issue
    else if (mode_register_zero[burst_mode_pkg::LOOP_RST_BIT])
      mode_register_zero[burst_mode_pkg::LOOP_RST_BIT] <= 1'b0;
  end

  // Mode register one store
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      mode_register_one <= burst_mode_pkg::MR_ONE_RESET;
    // R25: hold until own mode-set
    else if (mode_set && mode_sel == burst_mode_pkg::SEL_ONE)
      mode_register_one <= mode_addr;
  end

  // Loop reset pulse and register views
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      loop_reset <= 1'b0;
      mode_zero_view <= '0;
      mode_one_view <= '0;
      term_off <= 1'b0;
      term_strobe_en <= 1'b0;
    end
    else
    begin
      // R17: issue the requested reset
      loop_reset <= mode_set && mode_sel == burst_mode_pkg::SEL_ZERO
                    && mode_addr[burst_mode_pkg::LOOP_RST_BIT];
      mode_zero_view <= mode_register_zero;
      mode_one_view <= mode_register_one;
      // R21: termination off with outputs
      term_off <= output_off;
      // R22: only on eight-bit configuration
      term_strobe_en <= WIDE_X8 && mode_register_one[burst_mode_pkg::TERM_STROBE_BIT] && !output_off;
    end
  end

  // ***************************************************************
  // Read latency
  // ***************************************************************
  logic [4:0] cl_code;                  // Column latency code
  logic [5:0] column_latency;           // Clocks from internal read
  logic [5:0] additive_latency;         // Clocks held before internal read
  logic [5:0] read_latency;             // Total clocks to first beat

  assign cl_code = {mode_register_zero[12], mode_register_zero[6:4], mode_register_zero[2]};

  // Column latency table; unlisted codes fall back to the shortest
  always_comb
  begin
    unique case (cl_code)
      5'h00: column_latency = 6'h09;
      5'h01: column_latency = 6'h0a;
      5'h02: column_latency = 6'h0b;
      5'h03: column_latency = 6'h0c;
      5'h04: column_latency = 6'h0d;
      5'h05: column_latency = 6'h0e;
      5'h06: column_latency = 6'h0f;
      5'h07: column_latency = 6'h10;
      5'h08: column_latency = 6'h12;
      5'h09: column_latency = 6'h14;
      5'h0a: column_latency = 6'h16;
      5'h0b: column_latency = 6'h18;
      5'h0c: column_latency = 6'h17;
      5'h0d: column_latency = 6'h11;
      5'h0e: column_latency = 6'h13;
      5'h0f: column_latency = 6'h15;
      5'h10: column_latency = 6'h19;
      5'h11: column_latency = 6'h1a;
      5'h13: column_latency = 6'h1c;
      5'h14: column_latency = 6'h1d;
      5'h15: column_latency = 6'h1e;
      5'h16: column_latency = 6'h1f;
      5'h17: column_latency = 6'h20;
      default: column_latency = 6'h09;
    endcase
  end

  // Additive latency from its code; reserved treated as zero
  always_comb
  begin
    unique case (mode_register_one[burst_mode_pkg::AL_LSB +: 2])
      2'h1: additive_latency = column_latency - 6'h01;
      2'h2: additive_latency = column_latency - 6'h02;
      default: additive_latency = 6'h00;
    endcase
  end

  // R12: sum of the two latencies
  assign read_latency = additive_latency + column_latency;

  // ***************************************************************
  // Read command capture
  // ***************************************************************
  logic rd_chop;                        // Captured chop choice
  logic [2:0] rd_start;                 // Captured start column
  logic rd_fire;                        // First beat slot reached
  logic wr_chop_cmd;                    // Chop chosen for this write

  // R2: sampled with the command
  function automatic logic chop_of(input burst_mode_pkg::burst_len_t bl, input logic bc_n);
    chop_of = (bl == burst_mode_pkg::BURST_CHOP) || (bl == burst_mode_pkg::BURST_OTF && !bc_n);
  endfunction : chop_of

  // Capture start and chop choice of each read
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rd_chop <= 1'b0;
      rd_start <= 3'h0;
    end
    else if (rd_cmd)
    begin
      rd_chop <= chop_of(burst_len, burst_chop_n);
      rd_start <= start_col;
    end
  end

  // R11: whole-clock delay line
  latency_pipe #(.DEPTH(64)) u_lat (
    .clk(clk),
    .rst_b(rst_b),
    .start(rd_cmd),
    .delay(read_latency),
    .fire(rd_fire)
  );

  // ***************************************************************
  // Beat ordering and read sequencing
  // ***************************************************************
  logic [2:0] slot;                     // Beat slot count 0..7
  logic active;                         // Read burst under way
  logic [2:0] beat_idx;                 // Ordered column index
  logic in_tail;                        // Unused chop slot
  beat_link_if #(.W(BEAT_W)) beat_link ();

  // R1: order from length, type, start
  always_comb
  begin
    if (interleave)
      // R4: start XOR count
      beat_idx = rd_start ^ slot;
    else
      // R3: wrap inside nibble, then other nibble
      beat_idx = {rd_start[2] ^ slot[2], 2'(rd_start[1:0] + slot[1:0])};
  end

  // R5: chop stays within its nibble
  assign in_tail = rd_chop && slot[2];

  // Slot counter advances when the buffer is ready, or on a chop tail slot
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      active <= 1'b0;
      slot <= 3'h0;
    end
    else if (rd_fire)
    begin
      active <= 1'b1;
      slot <= 3'h0;
    end
    else if (active && (beat_link.ready || in_tail))
    begin
      slot <= slot + 3'h1;
      if (slot == 3'h7)
        active <= 1'b0;
    end
  end

  assign beat_link.valid = active && !in_tail && !output_off;
  assign beat_link.data = arr_beat[beat_idx];
  assign beat_link.last = rd_chop ? (slot == 3'h3) : (slot == 3'h7);

  beat_buffer #(.W(BEAT_W), .DEPTH(2)) u_buf (
    .clk(clk),
    .rst_b(rst_b),
    .in_side(beat_link),
    .out_valid(rd_valid),
    .out_ready(rd_ready),
    .out_data(rd_data),
    .out_last(rd_last)
  );

  // Driver enables and slot index
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      dq_oe_b <= 1'b1;
      dqs_oe_b <= 1'b1;
      rd_index <= 3'h0;
    end
    else
    begin
      // R6: tail slots and output_off leave pins floating
      dq_oe_b <= !(active && !in_tail) || output_off;
      dqs_oe_b <= !(active && !in_tail) || output_off;
      rd_index <= beat_idx;
    end
  end

  // ***************************************************************
  // Write path
  // ***************************************************************
  logic [3:0] wr_cnt;                   // Clocks to internal write start
  logic wr_pend;                        // Write awaiting start
  logic wr_chop;                        // Captured chop choice
  logic wr_nib;                         // Captured column bit 2
  logic [1:0] crc_cnt;                  // Clocks to CRC verdict
  logic crc_pend;                       // Commit waiting for CRC

  assign wr_chop_cmd = chop_of(burst_len, burst_chop_n);

  // Internal write start timing
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wr_pend <= 1'b0;
      wr_cnt <= 4'h0;
      wr_chop <= 1'b0;
      wr_nib <= 1'b0;
      wr_start <= 1'b0;
    end
    else
    begin
      wr_start <= 1'b0;
      if (wr_cmd)
      begin
        wr_pend <= 1'b1;
        wr_chop <= wr_chop_cmd;
        // R7: only column bit 2 kept
        wr_nib <= start_col[2];
        // R9: fixed chop pulls start in by two
        if (burst_len == burst_mode_pkg::BURST_CHOP)
          wr_cnt <= 4'(burst_mode_pkg::WRITE_START_BASE - burst_mode_pkg::CHOP_PULL_IN);
        // R10: select mode keeps eight-beat timing
        else
          wr_cnt <= 4'(burst_mode_pkg::WRITE_START_BASE);
      end
      else if (wr_pend)
      begin
        if (wr_cnt <= 4'h1)
        begin
          wr_pend <= 1'b0;
          wr_start <= 1'b1;
        end
        else
          wr_cnt <= wr_cnt - 4'h1;
      end
    end
  end

  // Commit after optional CRC check
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      crc_pend <= 1'b0;
      crc_cnt <= 2'h0;
      wr_commit <= 1'b0;
      wr_cancel <= 1'b0;
      wr_beat_map <= 8'h00;
    end
    else
    begin
      wr_commit <= 1'b0;
      wr_cancel <= 1'b0;
      if (wr_start)
      begin
        // R8: eight-beat writes fill 0..7 in order
        wr_beat_map <= !wr_chop ? 8'hff : (wr_nib ? 8'hf0 : 8'h0f);
        crc_pend <= mask_en && crc_en;
        crc_cnt <= 2'(burst_mode_pkg::CRC_CHECK_DELAY);
        wr_commit <= !(mask_en && crc_en);
      end
      else if (crc_pend)
      begin
        if (crc_cnt <= 2'h1)
        begin
          crc_pend <= 1'b0;
          // R15: mismatch cancels and discards
          wr_commit <= crc_ok;
          wr_cancel <= !crc_ok;
        end
        else
          crc_cnt <= crc_cnt - 2'h1;
      end
    end
  end

endmodule : burst_mode_core

// ---- verif/burst_mode_core_assertions.sv ----
// Port checker for the burst/mode block
`timescale 1ns/100ps
module burst_mode_core_assertions #(
  parameter int BEAT_W = 8, // Beat width
  parameter bit WIDE_X8 = 1'b1 // x8 build
)(
  input wire logic clk, // Clock
  input wire logic rst_b, // Reset
  input wire logic mode_set, // Mode-set
  input wire logic [21:0] mode_addr, // Mode bits
  input wire logic rd_cmd, // READ
  input wire logic wr_cmd, // WRITE
  input wire logic mask_en, // Masking
  input wire logic crc_en, // CRC on
  input wire logic crc_ok, // Verdict
  input wire logic rd_valid, // Beat valid
  input wire logic dq_oe_b, // Data enable
  input wire logic dqs_oe_b, // Strobe enable
  input wire logic term_off, // Outputs off
  input wire logic term_strobe_en, // Strobe pins
  input wire logic loop_reset, // Loop reset
  input wire logic wr_start, // Write start
  input wire logic wr_commit, // Commit
  input wire logic wr_cancel, // Cancel
  input wire logic [21:0] mode_zero_view, // Register zero
  input wire logic [21:0] mode_one_view // Register one
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  logic [1:0] quiet; // Clocks since mode-set, saturating
  // Gives register-derived outputs time to settle before comparing
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b) quiet <= 2'h0;
    else if (mode_set) quiet <= 2'h0;
    else if (quiet != 2'h3) quiet <= quiet + 2'h1;
  sequence s_chop_wr;
    wr_cmd && mode_zero_view[1:0] == burst_mode_pkg::BL_CHOP;
  endsequence
  sequence s_full_wr;
    wr_cmd && mode_zero_view[1:0] != burst_mode_pkg::BL_CHOP;
  endsequence
  // Shortest latency only: no additive part, column code zero
  sequence s_base_rd;
    rd_cmd && !term_off && mode_one_view[4:3] == 2'h0 && (mode_zero_view & 22'h001074) == 22'h0;
  endsequence
  a_loop_pulse: assert property (mode_set && mode_addr[20:18] == 3'h0 && mode_addr[8] |-> ##[1:2] loop_reset)
    else $error("loop reset pulse missing");
  a_loop_clear: assert property (quiet == 2'h3 |-> !mode_zero_view[8])
    else $error("loop reset bit stuck");
  a_strobe_off: assert property (quiet == 2'h3 |-> term_off == mode_one_view[12] &&
    term_strobe_en == (mode_one_view[11] && WIDE_X8 && !mode_one_view[12]))
    else $error("output off or strobe pins wrong");
  a_off_quiet: assert property (term_off |-> dq_oe_b && dqs_oe_b)
    else $error("drivers on while outputs off");
  a_hold_regs: assert property (!$past(mode_set) && !$past(mode_set, 2) |->
    $stable(mode_one_view) && $stable(mode_zero_view[7:0]))
    else $error("mode register changed without mode-set");
  a_wr_chop: assert property (s_chop_wr |-> ##3 wr_start)
    else $error("chop write start not early");
  a_wr_full: assert property (s_full_wr |-> ##5 wr_start)
    else $error("write start timing wrong");
  a_crc_verdict: assert property (wr_start && mask_en && crc_en |-> ##3 wr_cancel == !$past(crc_ok) && wr_commit == $past(crc_ok))
    else $error("CRC verdict not applied");
  a_rd_latency: assert property (s_base_rd |=> !rd_valid [*8] ##[1:3] rd_valid)
    else $error("first read beat at wrong clock");
endmodule : burst_mode_core_assertions
bind burst_mode_core burst_mode_core_assertions #(.BEAT_W(BEAT_W), .WIDE_X8(WIDE_X8)) burst_mode_core_assertions_i (.*);

// ---- verif/ctrl_model.sv ----
// Memory controller model driving mode-set and column commands
`timescale 1ns/100ps
module ctrl_model #(
  parameter int LOCK_CYCLES = 16 // Loop lock wait, shortened
)(
  input wire logic clk, // Clock
  output logic mode_set, // Mode-set strobe
  output logic [21:0] mode_addr, // Mode bits
  output logic rd_cmd, // READ
  output logic wr_cmd, // WRITE
  output logic [2:0] start_col, // Start column
  output logic burst_chop_n // Low chops
);
  initial
  begin
    {mode_set, rd_cmd, wr_cmd, burst_chop_n} = 4'h1;
    mode_addr = 22'h0;
    start_col = 3'h0;
  end
  // recovery fields at code zero, four clocks covers any recovery time
  task automatic mode_set_command(input logic [2:0] sel, input logic [21:0] bits);
    // select mapped, test and reserved bits zero
    mode_addr <= {1'b0, sel, 1'b0, bits[16:8], 1'b0, bits[6:0]};
    mode_set <= 1'b1;
    @(posedge clk);
    mode_set <= 1'b0;
    mode_addr <= ~mode_addr;
    repeat (bits[8] ? LOCK_CYCLES : 4) @(posedge clk);
  endtask : mode_set_command
  task automatic column(input logic rd, input logic [2:0] col, input logic bc_n);
    // chop line travels with the command
    {rd_cmd, wr_cmd, start_col, burst_chop_n} <= {rd, !rd, col, bc_n};
    @(posedge clk);
    {rd_cmd, wr_cmd, start_col, burst_chop_n} <= {2'h0, ~col, !bc_n};
    @(posedge clk);
  endtask : column
endmodule : ctrl_model

// ---- verif/burst_mode_core_tb.sv ----
// Self-checking bench for the burst/mode block
`timescale 1ns/100ps
module burst_mode_core_tb;
  logic clk, rst_b, mask_en, crc_en, crc_ok, rd_ready, stall, mode_set, rd_cmd, wr_cmd, burst_chop_n;
  logic rd_valid, rd_last, dq_oe_b, dqs_oe_b, term_off, term_strobe_en, loop_reset, wr_start, wr_commit, wr_cancel;
  logic [21:0] mode_addr, mode_zero_view, mode_one_view;
  logic [2:0] start_col, rd_index, col;
  logic [7:0] rd_data, wr_beat_map;
  logic [7:0] arr_beat [8];
  logic [8:0] rd_q [$]; // Expected last flag and read beat
  logic [8:0] wr_q [$]; // Expected cancel flag and beat map
  logic [1:0] bls [5] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h3}; // Length codes under test
  int ns [5] = '{8, 8, 4, 4, 8}; // Beats each code gives
  int err_count, n_tests, k, lat0, lat1;
  burst_mode_core burst_mode_core_i (.*);
  ctrl_model ctrl_model_i (.*);
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish
  // Receiver stalls at random when asked, to fill the buffer
  always @(posedge clk) rd_ready <= stall ? 1'($urandom_range(1)) : 1'b1;
  // Scoreboard: each result takes the oldest note
  always @(posedge clk)
  begin
    if (rst_b && rd_valid === 1'b1 && rd_ready === 1'b1) chk("read beat", {rd_last, rd_data}, rd_q.pop_front());
    if (rst_b && (wr_commit === 1'b1 || wr_cancel === 1'b1)) chk("write", {wr_cancel, wr_beat_map}, wr_q.pop_front());
  end
  task automatic do_read(input logic bc_n, input logic bt, input int n, output int lat);
    foreach (arr_beat[i]) arr_beat[i] <= 8'($urandom);
    col <= 3'($urandom);
    @(posedge clk);
    for (int c = 0; c < n; c++)
      rd_q.push_back({c == n - 1, arr_beat[bt ? col ^ c[2:0] : {col[2] ^ c[2], col[1:0] + c[1:0]}]});
    ctrl_model_i.column(1'b1, col, bc_n);
    lat = 0;
    while (rd_valid !== 1'b1 && lat < 60)
    begin
      @(posedge clk);
      lat++;
    end
    repeat (40) @(posedge clk);
    chk("beats left", rd_q.size(), 0);
  endtask : do_read
  task automatic do_write(input logic bc_n, input logic [8:0] exp);
    wr_q.push_back(exp);
    ctrl_model_i.column(1'b0, col, bc_n);
    repeat (12) @(posedge clk);
  endtask : do_write
  initial
  begin
    {rst_b, mask_en, crc_en, crc_ok, stall} = 5'h0;
    foreach (arr_beat[i]) arr_beat[i] = 8'h0;
    void'($urandom(61));
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    chk("reset state", {mode_zero_view, mode_one_view, dq_oe_b, dqs_oe_b}, {44'h0, 2'h3});
    for (int m = 0; m < 10; m++)
    begin
      k = m % 5;
      stall <= m[0];
      ctrl_model_i.mode_set_command(3'h0, {18'h0, m >= 5, 1'b0, bls[k]});
      do_read(k != 2, m >= 5, ns[k], lat0);
      do_write(k != 2, {1'b0, ns[k] == 4 ? (col[2] ? 8'hf0 : 8'h0f) : 8'hff});
    end
    ctrl_model_i.mode_set_command(3'h0, 22'h0);
    do_read(1'b1, 1'b0, 8, lat0);
    ctrl_model_i.mode_set_command(3'h1, 22'h000008);
    do_read(1'b1, 1'b0, 8, lat1);
    chk("added latency", 64'(lat1 - lat0), 64'h8);
    {mask_en, crc_en, crc_ok} <= 3'h6;
    do_write(1'b1, {1'b1, 8'hff});
    crc_ok <= 1'b1;
    do_write(1'b1, {1'b0, 8'hff});
    ctrl_model_i.mode_set_command(3'h1, 22'h000800);
    chk("strobe pins", term_strobe_en, 64'h1);
    ctrl_model_i.mode_set_command(3'h1, 22'h001800);
    chk("outputs off", {term_off, term_strobe_en}, 64'h2);
    do_read(1'b1, 1'b0, 0, lat0);
    ctrl_model_i.mode_set_command(3'h0, 22'h000100);
    chk("loop bit", mode_zero_view[8], 64'h0);
    tally_and_finish();
  end
  initial
  begin
    #300000;
    err_count++;
    tally_and_finish();
  end
endmodule : burst_mode_core_tb
